/* rtl/mlsc_cfg.svh */
/*
  Offsets, field positions, reset values and counts for the MAC interface
  loopback and start-of-packet control block.
  Assumes inclusion by bare name from the design modules and the bench modules.
*/
// Summary of operation
// - Local loopback enable turns MAC transmit frames back into the MAC receiver.
// - With local loopback, transmit suppression keeps looped data away from the PHY.
// - Remote loopback enable sends line receive data back out the transmitter.
// - With remote loopback, receive suppression withholds received data from the MAC.
// - Loopback register resets to 0x000A; bits 15 to 4 read-only.
// - Start-of-packet register resets to 0x001B; bits 15 to 6 read-only.
// - Receive indication produced only while receive enable bit 0 is set.
// - Transmit indication produced only while transmit enable bit 3 is set.
// - Transmit delimiter-trigger bit 4 makes transmit indication assert at delimiter.
// - Transmit preamble-check bit 5 applies an eight-byte preamble length check.
// - Receive enable plus delimiter-trigger bit 1: indicate on delimiter reception.
// - Receive delimiter-trigger clear: indicate as soon as RX_DV becomes active.
// - Receive indication stays asserted until the current frame ends.
// - Receive preamble-check bit 2 set, no delimiter: indicate after eight bytes.
// - Receive preamble-check clear: no indication without delimiter in eight bytes.
`ifndef MLSC_CFG_SVH
`define MLSC_CFG_SVH

// Register addresses
`define MLSC_ADDR_LOOPBACK   16'h8055
`define MLSC_ADDR_SOP_CTRL   16'h805A

// Writable masks and reset values
`define MLSC_LOOPBACK_MASK   16'h000F
`define MLSC_LOOPBACK_RST    16'h000A
`define MLSC_SOP_MASK        16'h003F
`define MLSC_SOP_RST         16'h001B

// Loopback field positions
`define MLSC_LB_LOCAL_EN     0
`define MLSC_LB_LOCAL_TXSUP  1
`define MLSC_LB_REMOTE_EN    2
`define MLSC_LB_REMOTE_RXSUP 3

// Start-of-packet field positions
`define MLSC_SOP_RX_EN       0
`define MLSC_SOP_RX_SFD      1
`define MLSC_SOP_RX_LEN      2
`define MLSC_SOP_TX_EN       3
`define MLSC_SOP_TX_SFD      4
`define MLSC_SOP_TX_LEN      5

// Preamble byte limit and delimiter octet
`define MLSC_PREAMBLE_BYTES  4'h8
`define MLSC_SFD_OCTET       8'hD5

`endif

/* rtl/mlsc_pkg.sv */
/*
  Types used by the start-of-packet detector alone.
  Assumes the constants header is available on the include path.
*/
package mlsc_pkg;
  // Detector states
  typedef enum logic [1:0] {
    MLSC_IDLE,
    MLSC_HUNT,
    MLSC_ACTIVE,
    MLSC_WAIT_END
  } mlsc_sop_state_t;
endpackage : mlsc_pkg

/* rtl/mlsc_sop_det.sv */
/*
  Start-of-packet indication for one direction of the MAC/PHY stream.
  Assumes byte-wide data qualified by a valid level lasting the whole frame.
*/
`timescale 1ns/10ps
`include "mlsc_cfg.svh"
module mlsc_sop_det (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Options
  input  wire logic       enable_i,
  input  wire logic       sfd_trigger_i,
  input  wire logic       len_check_i,
  // Byte stream
  input  wire logic       dv_i,
  input  wire logic [7:0] data_i,
  // Indication
  output logic            sop_o
);
  mlsc_pkg::mlsc_sop_state_t state;
  mlsc_pkg::mlsc_sop_state_t next_state;
  logic [3:0]                count;
  logic [3:0]                next_count;
  logic                      is_sfd;

  assign is_sfd = (data_i == `MLSC_SFD_OCTET);

  // Next state: hunt for delimiter, count preamble bytes, hold to frame end
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      mlsc_pkg::MLSC_IDLE: begin
        next_count = 4'h0;
        if (dv_i && enable_i) begin
          if (!sfd_trigger_i) begin
            next_state = mlsc_pkg::MLSC_ACTIVE;
          end else if (is_sfd) begin
            next_state = mlsc_pkg::MLSC_ACTIVE;
          end else begin
            next_state = mlsc_pkg::MLSC_HUNT;
            next_count = 4'h1;
          end
        end
      end
      mlsc_pkg::MLSC_HUNT: begin
        if (!dv_i) begin
          next_state = mlsc_pkg::MLSC_IDLE;
        end else if (is_sfd) begin
          next_state = mlsc_pkg::MLSC_ACTIVE;
        end else if (count >= `MLSC_PREAMBLE_BYTES - 4'h1) begin
          if (len_check_i) begin
            next_state = mlsc_pkg::MLSC_ACTIVE;
          end else begin
            next_state = mlsc_pkg::MLSC_WAIT_END;
          end
        end else begin
          next_count = count + 4'h1;
        end
      end
      mlsc_pkg::MLSC_ACTIVE: begin
        if (!dv_i) begin
          next_state = mlsc_pkg::MLSC_IDLE;
        end
      end
      mlsc_pkg::MLSC_WAIT_END: begin
        if (!dv_i) begin
          next_state = mlsc_pkg::MLSC_IDLE;
        end
      end
      default: begin
        next_state = mlsc_pkg::MLSC_IDLE;
      end
    endcase
    if (!enable_i) begin
      next_state = mlsc_pkg::MLSC_IDLE;
    end
  end

  // State registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= mlsc_pkg::MLSC_IDLE;
      count <= 4'h0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // Indication held while active
  assign sop_o = (state == mlsc_pkg::MLSC_ACTIVE) && enable_i;
endmodule : mlsc_sop_det

/* rtl/mlsc_top.sv */
/*
  MAC interface loopback and start-of-packet control: two configuration
  registers on the management map, loopback steering of the byte streams
  between MAC and PHY, and a start-of-packet indication for each direction.
  Assumes a single-cycle management access port with address, write strobe
  and read strobe, and byte streams synchronous to the system clock.
*/
`timescale 1ns/10ps
`include "mlsc_cfg.svh"
module mlsc_top (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // Management register access
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_hit_o,
  // MAC transmit stream in
  input  wire logic        mac_tx_en_i,
  input  wire logic [7:0]  mac_tx_data_i,
  // PHY receive stream in
  input  wire logic        phy_rx_dv_i,
  input  wire logic [7:0]  phy_rx_data_i,
  // Stream out to PHY transmitter
  output logic             phy_tx_en_o,
  output logic      [7:0]  phy_tx_data_o,
  // Stream out to MAC receiver
  output logic             mac_rx_dv_o,
  output logic      [7:0]  mac_rx_data_o,
  // Start-of-packet indications
  output logic             tx_start_of_packet_indication_o,
  output logic             rx_start_of_packet_indication_o
);
  logic [15:0] loopback_config;
  logic [15:0] next_loopback_config;
  logic [15:0] start_of_packet_control;
  logic [15:0] next_start_of_packet_control;
  logic [15:0] next_rdata;
  logic        next_tx_en;
  logic [7:0]  next_tx_data;
  logic        next_rx_dv;
  logic [7:0]  next_rx_data;
  logic        local_loop_enable;
  logic        local_loop_tx_suppress;
  logic        remote_loop_enable;
  logic        remote_loop_rx_suppress;
  logic [1:0]  addr_sel;

  // Address decode shared by read and write paths
  function automatic logic [1:0] mlsc_decode(input logic [15:0] addr);
    mlsc_decode = {addr == `MLSC_ADDR_SOP_CTRL, addr == `MLSC_ADDR_LOOPBACK};
  endfunction : mlsc_decode

  // Decoded register select and loopback fields
  assign addr_sel                = mlsc_decode(reg_addr_i);
  assign local_loop_enable       = loopback_config[`MLSC_LB_LOCAL_EN];
  assign local_loop_tx_suppress  = loopback_config[`MLSC_LB_LOCAL_TXSUP];
  assign remote_loop_enable      = loopback_config[`MLSC_LB_REMOTE_EN];
  assign remote_loop_rx_suppress = loopback_config[`MLSC_LB_REMOTE_RXSUP];

  // Register writes, reserved bits masked off
  always_comb begin
    next_loopback_config         = loopback_config;
    next_start_of_packet_control = start_of_packet_control;
    if (reg_wr_i && addr_sel[0]) begin
      next_loopback_config = reg_wdata_i & `MLSC_LOOPBACK_MASK;
    end
    if (reg_wr_i && addr_sel[1]) begin
      next_start_of_packet_control = reg_wdata_i & `MLSC_SOP_MASK;
    end
  end

  // Read data, unmapped addresses read zero
  always_comb begin
    next_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      case (addr_sel)
        2'b01:   next_rdata = loopback_config & `MLSC_LOOPBACK_MASK;
        2'b10:   next_rdata = start_of_packet_control & `MLSC_SOP_MASK;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  assign reg_hit_o = |addr_sel;

  // Configuration and read registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      loopback_config         <= `MLSC_LOOPBACK_RST;
      start_of_packet_control <= `MLSC_SOP_RST;
      reg_rdata_o             <= 16'h0000;
    end else begin
      loopback_config         <= next_loopback_config;
      start_of_packet_control <= next_start_of_packet_control;
      reg_rdata_o             <= next_rdata;
    end
  end

  // Stream steering toward the PHY transmitter
  always_comb begin
    next_tx_en   = mac_tx_en_i;
    next_tx_data = mac_tx_data_i;
    if (remote_loop_enable) begin
      next_tx_en   = phy_rx_dv_i;
      next_tx_data = phy_rx_data_i;
    end else if (local_loop_enable && local_loop_tx_suppress) begin
      next_tx_en   = 1'b0;
      next_tx_data = 8'h00;
    end
    if (!next_tx_en) begin
      next_tx_data = 8'h00;
    end
  end

  // Stream steering toward the MAC receiver
  always_comb begin
    next_rx_dv   = phy_rx_dv_i;
    next_rx_data = phy_rx_data_i;
    if (local_loop_enable) begin
      next_rx_dv   = mac_tx_en_i;
      next_rx_data = mac_tx_data_i;
    end else if (remote_loop_enable && remote_loop_rx_suppress) begin
      next_rx_dv   = 1'b0;
      next_rx_data = 8'h00;
    end
    if (!next_rx_dv) begin
      next_rx_data = 8'h00;
    end
  end

  // Stream output registers, one cycle latency
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      phy_tx_en_o   <= 1'b0;
      phy_tx_data_o <= 8'h00;
      mac_rx_dv_o   <= 1'b0;
      mac_rx_data_o <= 8'h00;
    end else begin
      phy_tx_en_o   <= next_tx_en;
      phy_tx_data_o <= next_tx_data;
      mac_rx_dv_o   <= next_rx_dv;
      mac_rx_data_o <= next_rx_data;
    end
  end

  // Receive indication watches the stream delivered to the MAC
  mlsc_sop_det u_rx_sop (
    .clk_sys_i     (clk_sys_i),
    .sys_rst_i     (sys_rst_i),
    .enable_i      (start_of_packet_control[`MLSC_SOP_RX_EN]),
    .sfd_trigger_i (start_of_packet_control[`MLSC_SOP_RX_SFD]),
    .len_check_i   (start_of_packet_control[`MLSC_SOP_RX_LEN]),
    .dv_i          (mac_rx_dv_o),
    .data_i        (mac_rx_data_o),
    .sop_o         (rx_start_of_packet_indication_o)
  );

  // Transmit indication watches the stream sent to the PHY
  mlsc_sop_det u_tx_sop (
    .clk_sys_i     (clk_sys_i),
    .sys_rst_i     (sys_rst_i),
    .enable_i      (start_of_packet_control[`MLSC_SOP_TX_EN]),
    .sfd_trigger_i (start_of_packet_control[`MLSC_SOP_TX_SFD]),
    .len_check_i   (start_of_packet_control[`MLSC_SOP_TX_LEN]),
    .dv_i          (phy_tx_en_o),
    .data_i        (phy_tx_data_o),
    .sop_o         (tx_start_of_packet_indication_o)
  );
endmodule : mlsc_top

/* tb/mlsc_asserts.sv */
/*
  Port checker for mlsc_top: register read-back, loopback steering and
  receive indication timing. Assumes a bind from the bench top file.
*/
`timescale 1ns/10ps
`include "mlsc_cfg.svh"
module mlsc_asserts (
  // Clock, reset and register port
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Streams and indications
  input wire logic        mac_tx_en_i,
  input wire logic [7:0]  mac_tx_data_i,
  input wire logic        phy_rx_dv_i,
  input wire logic [7:0]  phy_rx_data_i,
  input wire logic        phy_tx_en_o,
  input wire logic [7:0]  phy_tx_data_o,
  input wire logic        mac_rx_dv_o,
  input wire logic [7:0]  mac_rx_data_o,
  input wire logic        tx_start_of_packet_indication_o,
  input wire logic        rx_start_of_packet_indication_o
);
  logic [3:0] lb, next_lb;
  logic [5:0] sp, next_sp;
  logic [7:0] cnt, next_cnt;
  wire        rxi = rx_start_of_packet_indication_o;
  wire        txi = tx_start_of_packet_indication_o;
  // Register shadows and byte count of the MAC-bound frame
  always_comb begin
    next_lb = (reg_wr_i && reg_addr_i == `MLSC_ADDR_LOOPBACK) ? reg_wdata_i[3:0] : lb;
    next_sp = (reg_wr_i && reg_addr_i == `MLSC_ADDR_SOP_CTRL) ? reg_wdata_i[5:0] : sp;
    next_cnt = mac_rx_dv_o ? cnt + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_sys_i) begin
    lb <= sys_rst_i ? 4'hA : next_lb;
    sp <= sys_rst_i ? 6'h1B : next_sp;
    cnt <= sys_rst_i ? 8'h00 : next_cnt;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Delimiter within the first eight bytes; eighth byte without it
  sequence rx_sfd_s;
    mac_rx_dv_o && mac_rx_data_o == `MLSC_SFD_OCTET && cnt < 8'h08;
  endsequence
  sequence rx_eighth_s;
    mac_rx_dv_o && cnt == 8'h07 && mac_rx_data_o != `MLSC_SFD_OCTET;
  endsequence
  local_loop_a: assert property (lb[0] && mac_tx_en_i |=> mac_rx_dv_o &&
    mac_rx_data_o == $past(mac_tx_data_i)) else $error("local loop data lost");
  remote_loop_a: assert property (lb[2] && phy_rx_dv_i |=> phy_tx_en_o &&
    phy_tx_data_o == $past(phy_rx_data_i)) else $error("remote loop data lost");
  rd_loop_a: assert property (reg_rd_i && reg_addr_i == `MLSC_ADDR_LOOPBACK
    |=> reg_rdata_o == {12'h000, $past(lb)}) else $error("loopback read wrong");
  rd_sop_a: assert property (reg_rd_i && reg_addr_i == `MLSC_ADDR_SOP_CTRL
    |=> reg_rdata_o == {10'h000, $past(sp)}) else $error("sop control read wrong");
  rx_gate_a: assert property (!sp[0] |-> !rxi) else $error("rx indication while off");
  tx_gate_a: assert property (!sp[3] |-> !txi) else $error("tx indication while off");
  rx_end_a: assert property (!mac_rx_dv_o |=> !rxi) else $error("rx indication past end");
  rx_sfd_a: assert property (sp[1:0] == 2'b11 && next_sp[0] ##0 rx_sfd_s |=> rxi)
    else $error("rx indication missed delimiter");
  rx_len_a: assert property (sp[2:0] == 3'b111 && next_sp[0] ##0 rx_eighth_s |=> rxi)
    else $error("rx indication missed eighth byte");
  rx_nolen_a: assert property (sp[2:0] == 3'b011 && next_sp[2:0] == 3'b011 && !rxi
    ##0 rx_eighth_s |=> !rxi) else $error("rx indication without delimiter");
  tx_pass_a: assert property (!lb[2] && !(lb[0] && lb[1]) && mac_tx_en_i |=>
    phy_tx_en_o && phy_tx_data_o == $past(mac_tx_data_i)) else $error("tx path data lost");
  rx_pass_a: assert property (!lb[0] && !(lb[2] && lb[3]) && phy_rx_dv_i |=>
    mac_rx_dv_o && mac_rx_data_o == $past(phy_rx_data_i)) else $error("rx path data lost");
  tx_sup_a: assert property (lb[0] && lb[1] && !lb[2] |=> !phy_tx_en_o)
    else $error("tx suppression broken");
  rx_sup_a: assert property (lb[2] && lb[3] && !lb[0] |=> !mac_rx_dv_o)
    else $error("rx suppression broken");
endmodule : mlsc_asserts

/* tb/mlsc_src.sv */
/*
  Byte-stream source standing in for the MAC transmit or PHY receive path.
  Assumes go_i is a one-cycle pulse and pre_i, sfd_i hold through a frame.
*/
`timescale 1ns/10ps
`include "mlsc_cfg.svh"
module mlsc_src (
  // Clock and frame request
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [3:0] pre_i,
  input  wire logic       sfd_i,
  // Byte stream
  output logic            en_o = 1'b0,
  output logic      [7:0] data_o = 8'h00
);
  logic [3:0] n = 4'h0;
  logic       t = 1'b0;
  // Preamble, delimiter slot, two payload bytes; idle data toggles
  always @(negedge clk_i) begin
    t = ~t;
    if (n != 4'h0)
      n = (n == pre_i + 4'h3) ? 4'h0 : n + 4'h1;
    else if (go_i)
      n = 4'h1;
    en_o = (n != 4'h0);
    data_o = (n == 4'h0) ? {8{t}} : (n == pre_i + 4'h1 && sfd_i) ? `MLSC_SFD_OCTET :
             (n <= pre_i + 4'h1) ? 8'h55 : 8'h3C;
  end
endmodule : mlsc_src

/* tb/tb.sv */
/*
  Self-checking bench for mlsc_top: register port, loopback steering and
  start-of-packet indications. Assumes two mlsc_src models feed the streams.
*/
`timescale 1ns/10ps
`include "mlsc_cfg.svh"
module tb;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [15:0] reg_addr_i = 16'h0000;
  logic        reg_wr_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o, got;
  logic        reg_hit_o, mac_tx_en_i, phy_rx_dv_i, phy_tx_en_o, mac_rx_dv_o;
  logic [7:0]  mac_tx_data_i, phy_rx_data_i, phy_tx_data_o, mac_rx_data_o;
  logic        tx_start_of_packet_indication_o, rx_start_of_packet_indication_o;
  logic        go_mac = 1'b0, go_phy = 1'b0, sfd = 1'b0;
  logic [3:0]  pre = 4'h3;
  logic [7:0]  c_rx, c_tx, c_ri, c_ti;
  int          n_fail = 0, n_checks = 0;
  // Row: loopback, sop control, from PHY, preamble, delimiter, rx tx ri ti cycles
  typedef struct packed {logic [15:0] lb, sp; logic ph; logic [3:0] pr; logic sd;
                  logic [7:0] rx, tx, ri, ti;} mlsc_row_t;
  mlsc_row_t rows [13] = '{
    '{16'h000A, 16'h001B, 1'b0, 4'h7, 1'b1, 8'h00, 8'h0A, 8'h00, 8'h03},
    '{16'h0001, 16'h001B, 1'b0, 4'h3, 1'b1, 8'h06, 8'h06, 8'h03, 8'h03},
    '{16'h0003, 16'h001B, 1'b0, 4'h3, 1'b1, 8'h06, 8'h00, 8'h03, 8'h00},
    '{16'h0004, 16'h001B, 1'b1, 4'h3, 1'b1, 8'h06, 8'h06, 8'h03, 8'h03},
    '{16'h000C, 16'h001B, 1'b1, 4'h3, 1'b1, 8'h00, 8'h06, 8'h00, 8'h03},
    '{16'h000A, 16'h0019, 1'b1, 4'h3, 1'b1, 8'h06, 8'h00, 8'h06, 8'h00},
    '{16'h000A, 16'h001F, 1'b1, 4'h7, 1'b0, 8'h0A, 8'h00, 8'h03, 8'h00},
    '{16'h000A, 16'h001B, 1'b1, 4'h7, 1'b0, 8'h0A, 8'h00, 8'h00, 8'h00},
    '{16'h000A, 16'h001A, 1'b1, 4'h3, 1'b1, 8'h06, 8'h00, 8'h00, 8'h00},
    '{16'h000A, 16'h0013, 1'b0, 4'h3, 1'b1, 8'h00, 8'h06, 8'h00, 8'h00},
    '{16'h000A, 16'h000B, 1'b0, 4'h3, 1'b1, 8'h00, 8'h06, 8'h00, 8'h06},
    '{16'h000A, 16'h003B, 1'b0, 4'h7, 1'b0, 8'h00, 8'h0A, 8'h00, 8'h03},
    '{16'h0005, 16'h003B, 1'b0, 4'h3, 1'b1, 8'h06, 8'h00, 8'h03, 8'h00}};
  mlsc_top i_dut (.*);
  mlsc_src i_mac (.clk_i(clk_sys_i), .go_i(go_mac), .pre_i(pre), .sfd_i(sfd),
                  .en_o(mac_tx_en_i), .data_o(mac_tx_data_i));
  mlsc_src i_phy (.clk_i(clk_sys_i), .go_i(go_phy), .pre_i(pre), .sfd_i(sfd),
                  .en_o(phy_rx_dv_i), .data_o(phy_rx_data_i));
  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Register write and read, one strobe cycle each
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(negedge clk_sys_i);
    {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    got = reg_rdata_o;
  endtask : rd
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // Watchdog well beyond the expected run length
  initial begin
    #50us;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    foreach (rows[i]) begin
      wr(`MLSC_ADDR_LOOPBACK, rows[i].lb);
      wr(`MLSC_ADDR_SOP_CTRL, rows[i].sp);
      {pre, sfd} = {rows[i].pr, rows[i].sd};
      {c_rx, c_tx, c_ri, c_ti} = 32'h0000_0000;
      @(negedge clk_sys_i);
      if (rows[i].ph) go_phy <= 1'b1;
      else go_mac <= 1'b1;
      repeat (16) begin
        @(negedge clk_sys_i);
        {go_phy, go_mac} <= 2'b00;
        c_rx += 8'(mac_rx_dv_o);
        c_tx += 8'(phy_tx_en_o);
        c_ri += 8'(rx_start_of_packet_indication_o);
        c_ti += 8'(tx_start_of_packet_indication_o);
      end
      chk(16'(c_rx), 16'(rows[i].rx));
      chk(16'(c_tx), 16'(rows[i].tx));
      chk(16'(c_ri), 16'(rows[i].ri));
      chk(16'(c_ti), 16'(rows[i].ti));
      $display("row %0d done", i);
    end
    // Reset in mid-run restores both registers
    @(negedge clk_sys_i);
    sys_rst_i = 1'b1;
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    rd(`MLSC_ADDR_LOOPBACK);
    chk(got, `MLSC_LOOPBACK_RST);
    rd(`MLSC_ADDR_SOP_CTRL);
    chk(got, `MLSC_SOP_RST);
    // Reserved bits dropped, unmapped address refused
    wr(`MLSC_ADDR_LOOPBACK, 16'hFFFF);
    wr(`MLSC_ADDR_SOP_CTRL, 16'hFFFF);
    wr(16'h8056, 16'h0000);
    rd(16'h8056);
    chk(got, 16'h0000);
    chk(16'(reg_hit_o), 16'h0000);
    rd(`MLSC_ADDR_LOOPBACK);
    chk(got, 16'h000F);
    chk(16'(reg_hit_o), 16'h0001);
    rd(`MLSC_ADDR_SOP_CTRL);
    chk(got, 16'h003F);
    $display("register tests done");
    conclude();
  end
endmodule : tb
bind mlsc_top mlsc_asserts i_chk (.*);
